// file: smw_pkg.sv
/*
 * smw_pkg: constants and carrier types for the static memory write
 * waveform and wait-state logic.
 * assumes: one controller clock, synchronous active-high reset.
 */
package smw_pkg;
    localparam int SMW_NUM_CS = 6;
    localparam int SMW_NUM_BYTES = 4;
    localparam int SMW_SETUP_W = 6;
    localparam int SMW_PULSE_W = 7;
    localparam int SMW_CYCLE_W = 9;
    localparam int SMW_CNT_W = 10;
    localparam int SMW_SETUP_MSB_WEIGHT = 128;
    localparam int SMW_PULSE_MSB_WEIGHT = 256;
    localparam int SMW_CYCLE_MSB_WEIGHT = 256;
    localparam int SMW_CS_IDLE_CYCLES = 1;
    localparam int SMW_EARLY_READ_CYCLES = 1;

    // per chip select timing, grouped by type
    typedef struct packed {
        logic [SMW_SETUP_W-1:0] read_strobe_setup;
        logic [SMW_SETUP_W-1:0] read_cs_setup;
        logic [SMW_SETUP_W-1:0] write_strobe_setup;
        logic [SMW_SETUP_W-1:0] write_cs_setup;
    } smw_setup_t;

    typedef struct packed {
        logic [SMW_PULSE_W-1:0] read_strobe_pulse;
        logic [SMW_PULSE_W-1:0] read_cs_pulse;
        logic [SMW_PULSE_W-1:0] write_strobe_pulse;
        logic [SMW_PULSE_W-1:0] write_cs_pulse;
    } smw_pulse_t;

    typedef struct packed {
        logic [SMW_CYCLE_W-1:0] read_total_cycle;
        logic [SMW_CYCLE_W-1:0] write_total_cycle;
    } smw_cycle_t;

    typedef struct packed {
        smw_setup_t setup;
        smw_pulse_t pulse;
        smw_cycle_t cycle;
        logic write_by_strobe_mode;
        logic byte_write_mode;
    } smw_cs_cfg_t;

    // effective counts for one write waveform
    typedef struct packed {
        logic [SMW_CNT_W-1:0] setup;
        logic [SMW_CNT_W-1:0] pulse;
        logic [SMW_CNT_W-1:0] total;
    } smw_wave_t;

    typedef struct packed {
        logic [2:0] cs;
        logic is_write;
        logic [SMW_NUM_BYTES-1:0] byte_en;
    } smw_req_t;

    function automatic logic [SMW_CNT_W-1:0] smw_setup_cnt(input logic [SMW_SETUP_W-1:0] c);
        smw_setup_cnt = (c[5] ? SMW_CNT_W'(SMW_SETUP_MSB_WEIGHT) : '0)
            + SMW_CNT_W'(c[4:0]);
    endfunction : smw_setup_cnt

    function automatic logic [SMW_CNT_W-1:0] smw_pulse_cnt(input logic [SMW_PULSE_W-1:0] c);
        smw_pulse_cnt = (c[6] ? SMW_CNT_W'(SMW_PULSE_MSB_WEIGHT) : '0)
            + SMW_CNT_W'(c[5:0]);
    endfunction : smw_pulse_cnt

    function automatic logic [SMW_CNT_W-1:0] smw_cycle_cnt(input logic [SMW_CYCLE_W-1:0] c);
        smw_cycle_cnt = SMW_CNT_W'(c[8:7]) * SMW_CNT_W'(SMW_CYCLE_MSB_WEIGHT)
            + SMW_CNT_W'(c[6:0]);
    endfunction : smw_cycle_cnt
endpackage : smw_pkg

// file: smw_wave_gen.sv
/*
 * smw_wave_gen: one setup/pulse/hold strobe from a shared cycle counter.
 * assumes: pos counts 0..total-1 within the cycle; pulse at least one.
 */
module smw_wave_gen
    import smw_pkg::*;
(
    input wire logic active,
    input wire logic [SMW_CNT_W-1:0] pos,
    input wire smw_wave_t wave,
    output logic strobe_n,
    output logic past_setup
);
    wire logic [SMW_CNT_W-1:0] pulse_end = wave.setup + wave.pulse;
    // hold is whatever remains of total after setup and pulse
    assign past_setup = active && (pos >= wave.setup);
    assign strobe_n = !(past_setup && (pos < pulse_end));
endmodule : smw_wave_gen

// file: smw_idle_ctl.sv
/*
 * smw_idle_ctl: decides the idle cycle inserted before a new access.
 * assumes: previous-access facts are registered by the caller.
 */
module smw_idle_ctl
    import smw_pkg::*;
(
    input wire logic prev_valid,
    input wire logic prev_write,
    input wire logic [2:0] prev_cs,
    input wire logic prev_ctrl_hold_zero,
    input wire logic prev_cs_hold_zero,
    input wire logic prev_by_strobe,
    input wire logic strobe_fb_high,
    input wire smw_req_t req,
    input wire smw_cs_cfg_t cfg,
    output logic cs_idle,
    output logic early_read
);
    wire logic read_ctrl_setup_zero = (cfg.setup.read_strobe_setup == '0)
        && (cfg.setup.read_cs_setup == '0);
    wire logic same_cs = prev_valid && (prev_cs == req.cs);
    wire logic wr_to_rd = same_cs && prev_write && !req.is_write;
    wire logic cond_ctrl = prev_ctrl_hold_zero && read_ctrl_setup_zero;
    wire logic cond_cs = !prev_by_strobe && prev_cs_hold_zero
        && (cfg.setup.read_cs_setup == '0);
    wire logic cond_fb = prev_by_strobe && prev_ctrl_hold_zero && !strobe_fb_high;
    assign cs_idle = prev_valid && (prev_cs != req.cs);
    // early read never stacks on a chip-select idle
    assign early_read = wr_to_rd && (cond_ctrl || cond_cs || cond_fb);
endmodule : smw_idle_ctl

// file: smw_write_ctl.sv
/*
 * smw_write_ctl: write waveform generator and automatic wait-state logic
 * of a static memory controller, per chip select timing tables.
 * assumes: requests held until accepted; software keeps pulse nonzero and
 * setup plus pulse within total; reads timed elsewhere through rd_busy.
 */
//Behaviour
//- write strobe: high for setup, low for pulse, high for remaining hold.
//- write chip select timed from its own write setup, pulse, hold.
//- byte write lines copy the write strobe waveform in byte-write mode.
//- timings per chip select in cycles; hold derived from total length.
//- zero setup and hold keep signal asserted across back-to-back writes, same memory.
//- strobe mode: drive data from strobe setup end to cycle end.
//- chip-select mode: drive data from cs setup end to cycle end.
//- setup code: 128 times top bit plus low five bits.
//- pulse code: 256 times top bit plus low six bits.
//- cycle code: 256 times top two bits plus low seven bits.
//- setup, pulse, cycle values grouped per chip select by type.
//- strobe mode zero hold: address, selects, cs outlast strobe rise.
//- one idle cycle between transfers on different chip selects.
//- during chip-select idle all selects, write lines, cs, read high.
//- early-read idle only write then read, same cs, never stacked.
//- early read when write control hold zero and read setup zero.
//- cs-controlled write, cs hold zero, read cs setup zero: early read.
//- strobe mode zero hold: strobe feedback still low adds early read.
module smw_write_ctl
    import smw_pkg::*;
#(
    parameter int NUM_CS = SMW_NUM_CS,
    parameter int NUM_BYTES = SMW_NUM_BYTES
) (
    input wire logic clk,
    input wire logic rst,
    input wire smw_cs_cfg_t cs_cfg [NUM_CS],
    input wire logic req_valid,
    input wire smw_req_t req,
    output logic req_ready,
    input wire logic rd_busy,
    input wire logic write_strobe_fb,
    output logic write_strobe_n,
    output logic [NUM_BYTES-1:0] byte_write_strobe_n,
    output logic [NUM_BYTES-1:0] byte_select_n,
    output logic [NUM_CS-1:0] chip_select_n,
    output logic read_strobe_n,
    output logic data_out_en,
    output logic write_done,
    output logic idle_active
);
    typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_WRITE} smw_state_t;

    smw_state_t state_q, state_d;
    logic [SMW_CNT_W-1:0] pos_q, pos_d;
    smw_req_t cur_q;
    logic prev_valid_q, prev_write_q, prev_by_strobe_q;
    logic prev_ctrl_hold_zero_q, prev_cs_hold_zero_q;
    logic [2:0] prev_cs_q;
    logic strobe_active, cs_active;
    logic we_n, cs_wr_n, we_past, cs_past;
    logic cs_idle, early_read;
    logic hold_cs_q;

    // effective waveform of the selected chip select
    wire smw_cs_cfg_t cfg_cur = cs_cfg[cur_q.cs];
    wire smw_cs_cfg_t cfg_req = cs_cfg[req.cs];
    // hold facts come from the accepted request, so a read offered at cycle end sees them
    wire logic req_we_hz = (smw_setup_cnt(cfg_req.setup.write_strobe_setup)
        + smw_pulse_cnt(cfg_req.pulse.write_strobe_pulse))
        >= smw_cycle_cnt(cfg_req.cycle.write_total_cycle);
    wire logic req_cs_hz = (smw_setup_cnt(cfg_req.setup.write_cs_setup)
        + smw_pulse_cnt(cfg_req.pulse.write_cs_pulse))
        >= smw_cycle_cnt(cfg_req.cycle.write_total_cycle);
    wire smw_wave_t we_wave = '{setup: smw_setup_cnt(cfg_cur.setup.write_strobe_setup),
        pulse: smw_pulse_cnt(cfg_cur.pulse.write_strobe_pulse),
        total: smw_cycle_cnt(cfg_cur.cycle.write_total_cycle)};
    wire smw_wave_t cs_wave = '{setup: smw_setup_cnt(cfg_cur.setup.write_cs_setup),
        pulse: smw_pulse_cnt(cfg_cur.pulse.write_cs_pulse),
        total: smw_cycle_cnt(cfg_cur.cycle.write_total_cycle)};
    wire logic [SMW_CNT_W-1:0] last_pos = we_wave.total - SMW_CNT_W'(1);
    wire logic cycle_end = (state_q == ST_WRITE) && (pos_q >= last_pos);
    wire logic we_hold_zero = (we_wave.setup + we_wave.pulse) >= we_wave.total;
    wire logic writing = (state_q == ST_WRITE);

    assign strobe_active = writing;
    assign cs_active = writing;

    smw_wave_gen u_we_wave (
        .active(strobe_active),
        .pos(pos_q),
        .wave(we_wave),
        .strobe_n(we_n),
        .past_setup(we_past)
    );

    smw_wave_gen u_cs_wave (
        .active(cs_active),
        .pos(pos_q),
        .wave(cs_wave),
        .strobe_n(cs_wr_n),
        .past_setup(cs_past)
    );

    smw_idle_ctl u_idle (
        .prev_valid(prev_valid_q),
        .prev_write(prev_write_q),
        .prev_cs(prev_cs_q),
        .prev_ctrl_hold_zero(prev_ctrl_hold_zero_q),
        .prev_cs_hold_zero(prev_cs_hold_zero_q),
        .prev_by_strobe(prev_by_strobe_q),
        .strobe_fb_high(write_strobe_fb),
        .req(req),
        .cfg(cfg_req),
        .cs_idle(cs_idle),
        .early_read(early_read)
    );

    wire logic need_wait = cs_idle || early_read;
    wire logic can_start = req_valid && !rd_busy
        && ((state_q == ST_IDLE) || cycle_end || (state_q == ST_WAIT));
    // a write request opens a cycle; reads are only recorded for idle decisions
    wire logic start_now = can_start && !need_wait && req.is_write;
    wire logic idle_now = (state_q == ST_WAIT);

    always_comb begin
        state_d = state_q;
        pos_d = pos_q;
        unique case (state_q)
            ST_IDLE: begin
                if (can_start && need_wait) begin
                    state_d = ST_WAIT;
                end else if (start_now) begin
                    state_d = ST_WRITE;
                    pos_d = '0;
                end
            end
            ST_WAIT: begin
                // wait lasts one cycle, then a write starts or the state returns to idle
                state_d = start_now ? ST_WRITE : ST_IDLE;
                pos_d = '0;
            end
            ST_WRITE: begin
                if (!cycle_end) begin
                    pos_d = pos_q + SMW_CNT_W'(1);
                end else if (can_start && need_wait) begin
                    state_d = ST_WAIT;
                end else if (start_now) begin
                    pos_d = '0;
                end else begin
                    state_d = ST_IDLE;
                end
            end
        endcase
    end

    // wait state consumes the cs/early-read condition, so bypass it once inside
    assign req_ready = (can_start && !need_wait) || (idle_now && req_valid && !rd_busy);
    assign write_done = cycle_end;
    assign idle_active = idle_now;

    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= ST_IDLE;
            pos_q <= '0;
        end else begin
            state_q <= (idle_now && req_valid && !rd_busy && req.is_write) ? ST_WRITE : state_d;
            pos_q <= pos_d;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cur_q <= '0;
        end else if (req_ready && req_valid) begin
            cur_q <= req;
        end
    end

    // facts about the accepted access feed the next idle decision
    always_ff @(posedge clk) begin
        if (rst) begin
            prev_valid_q <= 1'b0;
            prev_write_q <= 1'b0;
            prev_cs_q <= '0;
            prev_ctrl_hold_zero_q <= 1'b0;
            prev_cs_hold_zero_q <= 1'b0;
            prev_by_strobe_q <= 1'b0;
        end else if (req_ready && req_valid) begin
            prev_valid_q <= 1'b1;
            prev_write_q <= req.is_write;
            prev_cs_q <= req.cs;
            prev_ctrl_hold_zero_q <= req.is_write
                && (cfg_req.write_by_strobe_mode ? req_we_hz : req_cs_hz);
            prev_cs_hold_zero_q <= req_cs_hz;
            prev_by_strobe_q <= cfg_req.write_by_strobe_mode;
        end
    end

    // strobe mode with zero hold: keep cs and selects one cycle past strobe rise
    always_ff @(posedge clk) begin
        if (rst) begin
            hold_cs_q <= 1'b0;
        end else begin
            hold_cs_q <= cycle_end && cfg_cur.write_by_strobe_mode && we_hold_zero;
        end
    end

    // an early-read wait keeps the held lines; only a chip-select idle drops them
    wire logic cs_low = (!cs_wr_n) || (hold_cs_q && !(idle_now && cs_idle));
    wire logic sel_low = (writing && !idle_now) || (hold_cs_q && !(idle_now && cs_idle));

    always_ff @(posedge clk) begin
        if (rst) begin
            write_strobe_n <= 1'b1;
            byte_write_strobe_n <= '1;
            byte_select_n <= '1;
            chip_select_n <= '1;
            read_strobe_n <= 1'b1;
            data_out_en <= 1'b0;
        end else begin
            write_strobe_n <= we_n || idle_now;
            for (int b = 0; b < NUM_BYTES; b++) begin
                byte_write_strobe_n[b] <= !(cfg_cur.byte_write_mode && !we_n
                    && cur_q.byte_en[b]) || idle_now;
                byte_select_n[b] <= !(!cfg_cur.byte_write_mode && sel_low
                    && cur_q.byte_en[b]);
            end
            for (int c = 0; c < NUM_CS; c++) begin
                chip_select_n[c] <= !(cs_low && (cur_q.cs == 3'(c)));
            end
            read_strobe_n <= 1'b1;
            data_out_en <= cfg_cur.write_by_strobe_mode ? (we_past || hold_cs_q)
                : (cs_past || hold_cs_q);
        end
    end

    sequence s_wait_then_write;
        (state_q == ST_WAIT) ##1 1'b1;
    endsequence

    cs_idle_one_a: assert property (@(posedge clk) disable iff (rst)
        (state_q == ST_WAIT) |=> (state_q != ST_WAIT))
        else $error("idle lasted more than one cycle");

    idle_lines_high_a: assert property (@(posedge clk) disable iff (rst)
        s_wait_then_write |-> (&byte_write_strobe_n && read_strobe_n && write_strobe_n))
        else $error("control line low after idle cycle");

    diff_cs_idle_a: assert property (@(posedge clk) disable iff (rst)
        (can_start && cs_idle && (state_q != ST_WAIT)) |=> (state_q == ST_WAIT))
        else $error("chip select change without idle");

    early_same_cs_a: assert property (@(posedge clk) disable iff (rst)
        early_read |-> (prev_cs_q == req.cs))
        else $error("early read across chip selects");

    strobe_setup_a: assert property (@(posedge clk) disable iff (rst)
        (writing && pos_q < we_wave.setup) |=> write_strobe_n)
        else $error("write strobe low during setup");

    strobe_pulse_a: assert property (@(posedge clk) disable iff (rst)
        (writing && pos_q >= we_wave.setup && pos_q < we_wave.setup + we_wave.pulse)
        |=> !write_strobe_n)
        else $error("write strobe high during pulse");

    data_drive_a: assert property (@(posedge clk) disable iff (rst)
        (writing && cfg_cur.write_by_strobe_mode && pos_q >= we_wave.setup) |=> data_out_en)
        else $error("data not driven after strobe setup");

    byte_copy_a: assert property (@(posedge clk) disable iff (rst)
        (writing && cfg_cur.byte_write_mode && cur_q.byte_en[0]) |=>
        (byte_write_strobe_n[0] == write_strobe_n))
        else $error("byte write line differs from write strobe");

    cs_outlast_a: assert property (@(posedge clk) disable iff (rst)
        $rose(hold_cs_q) && !(idle_now && cs_idle) |=> !chip_select_n[$past(cur_q.cs)])
        else $error("chip select released with strobe");
endmodule : smw_write_ctl

// file: smw_mem_model.sv
/*
 * smw_mem_model: write strobe feedback seen at the pad of a loaded external memory bus.
 * assumes: same clock as the controller; slow is set by the bench only between accesses.
 */
module smw_mem_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic write_strobe_n,
    input wire logic slow,
    output logic write_strobe_fb
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] lag_q;

    always_ff @(posedge clk) begin
        if (rst) lag_q <= 2'h3;
        else lag_q <= {lag_q[0], write_strobe_n};
    end

    // heavy load: the fall shows at once, the rise only two cycles later
    assign write_strobe_fb = slow ? (write_strobe_n & lag_q[1] & lag_q[0]) : write_strobe_n;
endmodule : smw_mem_model

// file: testbench.sv
/*
 * testbench: self-checking bench for the static memory write waveform and wait-state block.
 * assumes: smw_pkg, the design files and smw_mem_model are compiled before this file.
 */
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin errors++; \
    $display("ERROR %s expected %0h seen %0h", nm, ex, got); end end
module testbench;
    import smw_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {
        logic wr;
        int cs, ws, wp, cs_s, cs_p, tot, idle, gap;
        logic [3:0] be;
        logic mode, bw;
    } smw_note_t;
    logic clk = 1'b0;
    logic rst = 1'b1;
    smw_cs_cfg_t cfg [SMW_NUM_CS];
    logic req_valid = 1'b0;
    smw_req_t req = '0;
    logic rd_busy = 1'b0;
    logic slow = 1'b0;
    logic req_ready, fb, ws_n, rd_n, doe, wdone, idle;
    logic [3:0] bws_n, bs_n;
    logic [5:0] cs_n;
    int errors = 0, checked = 0, seed = 52488, idle_cnt = 0, last_t = 0, cyc = 0, pend = 0;
    int last_cs = 0;
    logic idle_chk = 1'b0;
    smw_note_t q[$];

    always #10 clk = ~clk;

    smw_write_ctl u_dut (.clk(clk), .rst(rst), .cs_cfg(cfg), .req_valid(req_valid), .req(req),
        .req_ready(req_ready), .rd_busy(rd_busy), .write_strobe_fb(fb), .write_strobe_n(ws_n),
        .byte_write_strobe_n(bws_n), .byte_select_n(bs_n), .chip_select_n(cs_n),
        .read_strobe_n(rd_n), .data_out_en(doe), .write_done(wdone), .idle_active(idle));
    smw_mem_model u_mem (.clk(clk), .rst(rst), .write_strobe_n(ws_n), .slow(slow),
        .write_strobe_fb(fb));

    function automatic int rnd(int n);
        return $unsigned($random(seed)) % n;
    endfunction : rnd

    // effective count: top field times its weight plus the low field
    function automatic int eff(int code, int lo, int wt);
        return (code >> lo) * wt + (code & ((1 << lo) - 1));
    endfunction : eff

    task automatic wrap_up();
        if (errors == 0 && checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : wrap_up

    // codes only; pulse codes stay nonzero and setup plus pulse within total
    task automatic setc(int c, int ws, int wp, int css, int csp, int tot, logic m, logic bw,
        int rs);
        cfg[c] <= '{setup: '{6'(rs), 6'(rs), 6'(ws), 6'(css)},
            pulse: '{7'h1, 7'h1, 7'(wp), 7'(csp)},
            cycle: '{9'(rs + 1), 9'(tot)},
            write_by_strobe_mode: m, byte_write_mode: bw};
    endtask : setc

    task automatic acc(int c, logic wr, logic [3:0] be, int idl, int gap);
        smw_note_t n;
        int i;
        n.wr = wr;
        n.cs = c;
        n.be = be;
        n.idle = idl;
        n.gap = gap;
        n.ws = eff(cfg[c].setup.write_strobe_setup, 5, 128);
        n.cs_s = eff(cfg[c].setup.write_cs_setup, 5, 128);
        n.wp = eff(cfg[c].pulse.write_strobe_pulse, 6, 256);
        n.cs_p = eff(cfg[c].pulse.write_cs_pulse, 6, 256);
        n.tot = eff(cfg[c].cycle.write_total_cycle, 7, 256);
        n.mode = cfg[c].write_by_strobe_mode;
        n.bw = cfg[c].byte_write_mode;
        q.push_back(n);
        req_valid <= 1'b1;
        req <= '{cs: 3'(c), is_write: wr, byte_en: be};
        for (i = 0; i < 2000; i++) begin
            @(negedge clk);
            if (req_ready === 1'b1) break;
        end
        if (i == 2000) begin
            errors++;
            wrap_up();
        end
        @(posedge clk);
    endtask : acc

    task automatic rd(int c, int idl);
        acc(c, 1'b0, 4'h0, idl, -1);
        req_valid <= 1'b0;
        rd_busy <= 1'b1;
        repeat (3) @(posedge clk);
        rd_busy <= 1'b0;
    endtask : rd

    task automatic drain();
        int i;
        req_valid <= 1'b0;
        repeat (2) @(posedge clk);
        for (i = 0; i < 3000 && pend != 0; i++) @(posedge clk);
        if (pend != 0) begin
            errors++;
            wrap_up();
        end
        repeat (3) @(posedge clk);
    endtask : drain

    // position 0 runs after the accepting edge; its outputs register one edge later
    task automatic wave(smw_note_t n);
        int p, st, cl;
        pend++;
        repeat (1) @(posedge clk);
        for (p = 0; p < n.tot; p++) begin
            @(negedge clk);
            st = (p >= n.ws && p < n.ws + n.wp) ? 0 : 1;
            cl = (p >= n.cs_s && p < n.cs_s + n.cs_p) ? 1 : 0;
            `CHK("write_strobe", 1'(st), ws_n)
            `CHK("chip_select", ~(6'(cl) << n.cs), cs_n)
            if (n.bw) `CHK("byte_write", ~(st != 0 ? 4'h0 : n.be), bws_n)
            `CHK("data_drive", 1'(p >= (n.mode ? n.ws : n.cs_s)), doe)
            `CHK("read_strobe", 1'b1, rd_n)
        end
        if (n.mode && n.ws + n.wp == n.tot) begin
            @(negedge clk);
            `CHK("cs_after_strobe", 1'b0, cs_n[n.cs])
        end
        pend--;
    endtask : wave

    always @(negedge clk) begin
        // registered lines show the idle one cycle after the wait state
        if (!rst && idle_chk) `CHK("idle_lines", 16'hffff, {cs_n, bs_n, bws_n, rd_n, ws_n})
        idle_chk = 1'b0;
        if (!rst && idle === 1'b1) begin
            idle_cnt++;
            idle_chk = (int'(req.cs) != last_cs);
        end
    end

    always @(posedge clk) begin : mon
        smw_note_t n;
        cyc++;
        if (!rst && req_valid && req_ready === 1'b1) begin
            n = q.pop_front();
            if (n.idle >= 0) `CHK("idle_cycles", n.idle, idle_cnt)
            if (n.gap >= 0) `CHK("accept_gap", n.gap, cyc - last_t)
            idle_cnt = 0;
            last_t = cyc;
            last_cs = n.cs;
            if (n.wr) fork wave(n); join_none
        end
    end

    initial begin
        int i, c, pc;
        for (i = 0; i < SMW_NUM_CS; i++) cfg[i] = '0;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        for (c = 0; c < SMW_NUM_CS; c++) begin
            setc(c, rnd(4), 1 + rnd(4), rnd(4), 1 + rnd(4), 8 + rnd(3), rnd(2), rnd(2), 1);
        end
        @(posedge clk);
        pc = -1;
        for (i = 0; i < 16; i++) begin
            c = rnd(SMW_NUM_CS);
            acc(c, 1'b1, 4'(rnd(16)), pc < 0 ? -1 : int'(c != pc), -1);
            pc = c;
        end
        drain();
        // zero setup and hold, chip-select controlled, then a read with no setup
        setc(0, 0, 3, 0, 3, 3, 1'b0, 1'b0, 0);
        @(posedge clk);
        acc(0, 1'b1, 4'hf, -1, -1);
        acc(0, 1'b1, 4'hf, 0, 3);
        rd(0, 1);
        drain();
        // strobe controlled, zero hold, slow pad: read setup nonzero still waits
        setc(1, 1, 2, 0, 3, 3, 1'b1, 1'b1, 1);
        slow <= 1'b1;
        @(posedge clk);
        acc(1, 1'b1, 4'h5, -1, -1);
        rd(1, 1);
        drain();
        slow <= 1'b0;
        // hold present: no early read
        setc(2, 1, 2, 1, 2, 4, 1'b1, 1'b0, 0);
        @(posedge clk);
        acc(2, 1'b1, 4'h3, -1, -1);
        rd(2, 0);
        drain();
        // chip select change costs exactly one cycle, never stacked with early read
        setc(3, 0, 2, 0, 2, 2, 1'b0, 1'b0, 0);
        setc(4, 0, 2, 0, 2, 2, 1'b0, 1'b0, 0);
        @(posedge clk);
        acc(3, 1'b1, 4'hf, -1, -1);
        acc(4, 1'b1, 4'hf, 1, 3);
        rd(3, 1);
        drain();
        // top bits of every write code set
        setc(5, 6'h21, 7'h42, 6'h20, 7'h41, 9'h100, 1'b1, 1'b0, 1);
        @(posedge clk);
        acc(5, 1'b1, 4'hf, -1, -1);
        drain();
        wrap_up();
    end
endmodule : testbench
